//--- shared/spo_map.svh
/*
 Servo panel operator: register offsets, field positions, reset values, timing.
 Assumes a 20 MHz system clock and byte-addressed 32-bit register words.
*/
`ifndef SPO_MAP_SVH
`define SPO_MAP_SVH
// ==========================================
// Register offsets
`define SPO_ADDR_CTRL     8'h00
`define SPO_ADDR_SPD_TH   8'h04
`define SPO_ADDR_POS_TH   8'h08
`define SPO_ADDR_ROT_TH   8'h0c
`define SPO_ADDR_EMIN     8'h10
`define SPO_ADDR_EMAX     8'h14
`define SPO_ADDR_STATUS   8'h18
`define SPO_ADDR_PSEL     8'h1c
`define SPO_ADDR_PDATA    8'h20
`define SPO_ADDR_ALM_CLR  8'h24
// ==========================================
// Fields
`define SPO_CTRL_POS_BIT  0
`define SPO_CTRL_TRQ_BIT  1
`define SPO_ST_CODE_LSB   8
`define SPO_ST_MODE_LSB   12
`define SPO_ST_EDIT_BIT   14
`define SPO_ST_ALM_BIT    15
`define SPO_ST_ANUM_LSB   16
`define SPO_KEY_INC       0
`define SPO_KEY_DEC       1
`define SPO_KEY_MODE      2
`define SPO_KEY_ENT       3
// ==========================================
// Reset values and fixed thresholds
`define SPO_RST_SPD_TH    16'h000a
`define SPO_RST_POS_TH    16'h000a
`define SPO_RST_ROT_TH    16'h0014
`define SPO_RST_EMIN      16'h0000
`define SPO_RST_EMAX      16'hffff
`define SPO_TRQ_TH_PCT    16'h000a
`define SPO_FAST_STEP     16'h000a
// ==========================================
// Timing
`define SPO_CLK_HZ        20000000
`define SPO_HOLD_MS       500
`define SPO_RPT_MS        50
`define SPO_PULSE_WIN_MS  1
`endif

//--- shared/spo_pkg.sv
/*
 Servo panel operator: shared types.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spo_pkg;
    typedef enum logic [1:0] {
        spo_mode_status,
        spo_mode_param,
        spo_mode_monitor,
        spo_mode_utility
    } spo_mode_e;
    typedef enum logic [2:0] {
        spo_code_bb,
        spo_code_run,
        spo_code_fwd_stop,
        spo_code_rev_stop,
        spo_code_alarm
    } spo_code_e;
    typedef logic [15:0] spo_val_t;
endpackage

//--- shared/spo_key_if.sv
/*
 Key event carrier between the key decoder and the panel core.
 Assumes one clock domain.
*/
`timescale 1ns/1ns
interface spo_key_if;
    logic [3:0] press;
    logic [1:0] rpt;
    modport drv (output press, output rpt);
    modport rcv (input press, input rpt);
endinterface

//--- core/spo_key_decode.sv
/*
 Key decoder: one pulse per press, auto-repeat on held inc/dec.
 Assumes keys are debounced, synchronous and active high.
*/
`timescale 1ns/1ns
`include "spo_map.svh"
module spo_key_decode #(
    parameter int HOLD_CYC = 10000000,
    parameter int RPT_CYC  = 1000000
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] key_in,
    spo_key_if.drv          keys
);
    logic [3:0]  prev_r;
    logic [31:0] hold_r;
    logic        adj_held;
    logic        tick;
    // Only one adjust key held counts; both at once means nothing
    assign adj_held = key_in[`SPO_KEY_INC] ^ key_in[`SPO_KEY_DEC];
    assign tick     = adj_held && (hold_r == 32'(HOLD_CYC - 1));
    // ==========================================
    // Press edges
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_r     <= 4'h0;
            keys.press <= 4'h0;
        end else begin
            prev_r     <= key_in;
            keys.press <= key_in & ~prev_r;
        end
    end
    // ==========================================
    // Hold repeat
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hold_r   <= 32'h0;
            keys.rpt <= 2'h0;
        end else begin
            keys.rpt <= key_in[1:0] & {2{tick}};
            if (!adj_held || key_in != prev_r) begin
                hold_r <= 32'h0;
            end else if (tick) begin
                hold_r <= 32'(HOLD_CYC - RPT_CYC);
            end else begin
                hold_r <= hold_r + 32'h1;
            end
        end
    end
endmodule

//--- core/spo_flag_eval.sv
/*
 Status bit evaluator for the status display.
 Assumes signed speed, torque and error samples in display units.
*/
`timescale 1ns/1ns
`include "spo_map.svh"
module spo_flag_eval (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        pos_ctrl,
    input  wire logic        trq_mode,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] speed_ref,
    input  wire logic [15:0] torque_ref,
    input  wire logic [15:0] position_err,
    input  wire logic        ref_act,
    input  wire logic        err_clr_input,
    input  wire logic        servo_on,
    input  wire logic        ctrl_pwr_on,
    input  wire logic        main_pwr_ok,
    input  wire logic [15:0] spd_th,
    input  wire logic [15:0] pos_th,
    input  wire logic [15:0] rot_th,
    output logic      [6:0]  flags
);
    function automatic logic [16:0] mag(input logic [16:0] v);
        mag = v[16] ? 17'(-v) : v;
    endfunction
    logic [16:0] spd_err;
    assign spd_err = mag({motor_speed[15], motor_speed} - {speed_ref[15], speed_ref});
    // ==========================================
    // Flags
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= 7'h0;
        end else if (pos_ctrl) begin
            flags[0] <= mag({position_err[15], position_err}) < {1'b0, pos_th};
            flags[3] <= ref_act;
            flags[4] <= err_clr_input;
        end else begin
            flags[0] <= trq_mode || spd_err <= {1'b0, spd_th};
            flags[3] <= mag({speed_ref[15], speed_ref}) > {1'b0, rot_th};
            flags[4] <= mag({torque_ref[15], torque_ref}) > {1'b0, `SPO_TRQ_TH_PCT};
        end
        if (!sys_rst) begin
            flags[1] <= !servo_on;
            flags[2] <= ctrl_pwr_on;
            flags[5] <= main_pwr_ok;
            flags[6] <= mag({motor_speed[15], motor_speed}) > {1'b0, rot_th};
        end
    end
endmodule

//--- core/spo_panel.sv
/*
 Servo panel operator core: mode sequencing, alarm reset, status display,
 parameter selection and editing, software register port.
 Assumes synchronous inputs, one clock, and a master that never overlaps strobes.
*/
`timescale 1ns/1ns
`include "spo_map.svh"

// ==========================================

module spo_panel #(
    parameter int NUM_PARAM = 16,
    parameter int HOLD_CYC  = int'(64'(`SPO_HOLD_MS) * 64'(`SPO_CLK_HZ) / 64'd1000),
    parameter int RPT_CYC   = int'(64'(`SPO_RPT_MS) * 64'(`SPO_CLK_HZ) / 64'd1000),
    parameter int PULSE_WIN = int'(64'(`SPO_PULSE_WIN_MS) * 64'(`SPO_CLK_HZ) / 64'd1000)
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  key_in,
    input  wire logic        alarm_reset_input,
    input  wire logic        forward_overtravel_input,
    input  wire logic        reverse_overtravel_input,
    input  wire logic        servo_on,
    input  wire logic        ctrl_pwr_on,
    input  wire logic        main_pwr_ok,
    input  wire logic        err_clr_input,
    input  wire logic        ref_pulse_in,
    input  wire logic [15:0] motor_speed,
    input  wire logic [15:0] speed_ref,
    input  wire logic [15:0] torque_ref,
    input  wire logic [15:0] position_err,
    input  wire logic        alarm_active,
    input  wire logic [7:0]  alarm_num,
    output logic             alarm_clear,

    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,

    output spo_pkg::spo_mode_e disp_mode,
    output logic      [6:0]  disp_flags,
    output spo_pkg::spo_code_e disp_code,
    output logic      [7:0]  disp_alarm,
    output logic             disp_editing,
    output logic      [7:0]  disp_param_num,
    output spo_pkg::spo_val_t disp_param_val
);
    localparam int IDX_W = $clog2(NUM_PARAM);

    function automatic spo_pkg::spo_mode_e next_mode(input spo_pkg::spo_mode_e m);
        case (m)
            spo_pkg::spo_mode_status:  next_mode = spo_pkg::spo_mode_param;
            spo_pkg::spo_mode_param:   next_mode = spo_pkg::spo_mode_monitor;
            spo_pkg::spo_mode_monitor: next_mode = spo_pkg::spo_mode_utility;
            default:                   next_mode = spo_pkg::spo_mode_status;
        endcase
    endfunction

    // Clamps rather than wraps, so a held key parks at the limit
    function automatic spo_pkg::spo_val_t step_val(
        input spo_pkg::spo_val_t v,
        input logic              up,
        input spo_pkg::spo_val_t st,
        input spo_pkg::spo_val_t lo,
        input spo_pkg::spo_val_t hi
    );
        logic [16:0] t;
        t = 17'h0;

        if (up) begin
            t = {1'b0, v} + {1'b0, st};
            step_val = (t > {1'b0, hi}) ? hi : t[15:0];
        end else begin
            t = {1'b0, v} - {1'b0, st};
            step_val = (t[16] || t[15:0] < lo) ? lo : t[15:0];
        end
    endfunction

    spo_key_if keys ();

    spo_pkg::spo_mode_e mode_r;
    spo_pkg::spo_code_e code_nxt;
    spo_pkg::spo_val_t  param_mem [NUM_PARAM];
    spo_pkg::spo_val_t  edit_r;
    spo_pkg::spo_val_t  spd_th_r;
    spo_pkg::spo_val_t  pos_th_r;
    spo_pkg::spo_val_t  rot_th_r;
    spo_pkg::spo_val_t  emin_r;
    spo_pkg::spo_val_t  emax_r;

    logic [1:0]         ctrl_r;
    logic [IDX_W-1:0]   sel_r;
    logic [IDX_W-1:0]   sw_idx_r;
    logic               editing_r;
    logic               arst_prev_r;
    logic               sw_clr_r;
    logic [31:0]        pulse_r;
    logic               ref_act;
    logic [6:0]         flags;

    logic               k_inc;
    logic               k_dec;
    logic               k_mode;
    logic               k_ent;
    logic               r_inc;
    logic               r_dec;
    logic               in_param;
    logic               wr_hit;

    assign k_inc    = keys.press[`SPO_KEY_INC];
    assign k_dec    = keys.press[`SPO_KEY_DEC];
    assign k_mode   = keys.press[`SPO_KEY_MODE];
    assign k_ent    = keys.press[`SPO_KEY_ENT];
    assign r_inc    = keys.rpt[`SPO_KEY_INC];
    assign r_dec    = keys.rpt[`SPO_KEY_DEC];

    assign in_param = (mode_r == spo_pkg::spo_mode_param);
    assign ref_act  = (pulse_r != 32'h0);
    assign wr_hit   = reg_wr && (reg_addr == `SPO_ADDR_PDATA);

    // ==========================================
    // Submodules
    spo_key_decode #(
        .HOLD_CYC (HOLD_CYC),
        .RPT_CYC  (RPT_CYC)
    ) spo_key_decode_inst (
        .clk     (clk),
        .sys_rst (sys_rst),
        .key_in  (key_in),
        .keys    (keys.drv)
    );

    spo_flag_eval spo_flag_eval_inst (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .pos_ctrl      (ctrl_r[`SPO_CTRL_POS_BIT]),
        .trq_mode      (ctrl_r[`SPO_CTRL_TRQ_BIT]),
        .motor_speed   (motor_speed),
        .speed_ref     (speed_ref),
        .torque_ref    (torque_ref),
        .position_err  (position_err),
        .ref_act       (ref_act),
        .err_clr_input (err_clr_input),
        .servo_on      (servo_on),
        .ctrl_pwr_on   (ctrl_pwr_on),
        .main_pwr_ok   (main_pwr_ok),
        .spd_th        (spd_th_r),
        .pos_th        (pos_th_r),
        .rot_th        (rot_th_r),
        .flags         (flags)
    );

    // ==========================================
    // Configuration registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r   <= 2'h0;
            spd_th_r <= `SPO_RST_SPD_TH;
            pos_th_r <= `SPO_RST_POS_TH;
            rot_th_r <= `SPO_RST_ROT_TH;
            emin_r   <= `SPO_RST_EMIN;
            emax_r   <= `SPO_RST_EMAX;
            sw_idx_r <= '0;
            sw_clr_r <= 1'b0;
        end else begin
            sw_clr_r <= reg_wr && (reg_addr == `SPO_ADDR_ALM_CLR) && reg_wdata[0];

            if (reg_wr) begin
                case (reg_addr)
                    `SPO_ADDR_CTRL:   ctrl_r   <= reg_wdata[1:0];
                    `SPO_ADDR_SPD_TH: spd_th_r <= reg_wdata[15:0];
                    `SPO_ADDR_POS_TH: pos_th_r <= reg_wdata[15:0];
                    `SPO_ADDR_ROT_TH: rot_th_r <= reg_wdata[15:0];
                    `SPO_ADDR_EMIN:   emin_r   <= reg_wdata[15:0];
                    `SPO_ADDR_EMAX:   emax_r   <= reg_wdata[15:0];
                    `SPO_ADDR_PSEL:   sw_idx_r <= reg_wdata[IDX_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================
    // Basic mode sequence
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= spo_pkg::spo_mode_status;
        end else if (k_mode && !editing_r) begin
            // Mode while editing only stores; it must not also leave the mode
            mode_r <= next_mode(mode_r);
        end
    end

    // ==========================================
    // Alarm reset
    // Edge, not level: a held pin must not clear each new alarm
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            arst_prev_r <= 1'b0;
            alarm_clear <= 1'b0;
        end else begin
            arst_prev_r <= alarm_reset_input;
            alarm_clear <= (k_ent && mode_r == spo_pkg::spo_mode_status)
                         || (alarm_reset_input && !arst_prev_r)
                         || sw_clr_r;
        end
    end

    // ==========================================
    // Reference pulse activity window
    // A lone pulse holds the flag for one window, so slow trains still read lit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse_r <= 32'h0;
        end else if (ref_pulse_in) begin
            pulse_r <= 32'(PULSE_WIN);
        end else if (ref_act) begin
            pulse_r <= pulse_r - 32'h1;
        end
    end

    // ==========================================
    // Status code
    always_comb begin
        if (alarm_active) begin
            code_nxt = spo_pkg::spo_code_alarm;
        end else if (!forward_overtravel_input) begin
            code_nxt = spo_pkg::spo_code_fwd_stop;
        end else if (!reverse_overtravel_input) begin
            code_nxt = spo_pkg::spo_code_rev_stop;
        end else if (servo_on) begin
            code_nxt = spo_pkg::spo_code_run;
        end else begin
            code_nxt = spo_pkg::spo_code_bb;
        end
    end

    // ==========================================
    // Parameter select and edit
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_r     <= '0;
            edit_r    <= 16'h0;
            editing_r <= 1'b0;
            for (int i = 0; i < NUM_PARAM; i++) begin
                param_mem[i] <= 16'h0;
            end
        end else begin
            if (wr_hit) begin
                param_mem[sw_idx_r] <= reg_wdata[15:0];
            end

            if (in_param && !editing_r) begin
                if (k_inc) begin
                    sel_r <= (sel_r == IDX_W'(NUM_PARAM - 1)) ? '0 : sel_r + 1'b1;
                end else if (k_dec) begin
                    sel_r <= (sel_r == '0) ? IDX_W'(NUM_PARAM - 1) : sel_r - 1'b1;
                end else if (k_ent) begin
                    edit_r    <= param_mem[sel_r];
                    editing_r <= 1'b1;
                end
            end else if (editing_r) begin
                if (k_ent || k_mode) begin
                    param_mem[sel_r] <= edit_r;
                    editing_r        <= 1'b0;
                end else if (k_inc || k_dec) begin
                    edit_r <= step_val(edit_r, k_inc, 16'h1, emin_r, emax_r);
                end else if (r_inc || r_dec) begin
                    edit_r <= step_val(edit_r, r_inc, `SPO_FAST_STEP, emin_r, emax_r);
                end
            end
        end
    end

    // ==========================================
    // Register read port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `SPO_ADDR_CTRL:   reg_rdata <= {30'h0, ctrl_r};
                `SPO_ADDR_SPD_TH: reg_rdata <= {16'h0, spd_th_r};
                `SPO_ADDR_POS_TH: reg_rdata <= {16'h0, pos_th_r};
                `SPO_ADDR_ROT_TH: reg_rdata <= {16'h0, rot_th_r};
                `SPO_ADDR_EMIN:   reg_rdata <= {16'h0, emin_r};
                `SPO_ADDR_EMAX:   reg_rdata <= {16'h0, emax_r};
                `SPO_ADDR_STATUS: reg_rdata <= {8'h0, alarm_num, alarm_active, editing_r,
                                                mode_r, 1'b0, code_nxt, 1'b0, flags};
                `SPO_ADDR_PSEL:   reg_rdata <= 32'(sw_idx_r);
                `SPO_ADDR_PDATA:  reg_rdata <= {16'h0, param_mem[sw_idx_r]};
                default:          reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ==========================================
    // Display outputs
    assign disp_mode  = mode_r;
    assign disp_flags = flags;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            disp_code      <= spo_pkg::spo_code_bb;
            disp_alarm     <= 8'h0;
            disp_editing   <= 1'b0;
            disp_param_num <= 8'h0;
            disp_param_val <= 16'h0;
        end else begin
            disp_code      <= code_nxt;
            disp_alarm     <= alarm_num;
            disp_editing   <= editing_r;
            disp_param_num <= 8'(sel_r);
            disp_param_val <= editing_r ? edit_r : param_mem[sel_r];
        end
    end
endmodule

//--- testbench/spo_panel_properties.sv
/*
 Port checker for the panel core.
 Assumes binding into spo_panel, one clock, synchronous high reset.
*/
`timescale 1ns/1ns
module spo_panel_properties (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic [3:0]         key_in,
    input wire logic               alarm_reset_input,
    input wire logic               forward_overtravel_input,
    input wire logic               servo_on,
    input wire logic               ctrl_pwr_on,
    input wire logic               main_pwr_ok,
    input wire logic               alarm_active,
    input wire logic               alarm_clear,
    input wire spo_pkg::spo_mode_e disp_mode,
    input wire logic [6:0]         disp_flags,
    input wire spo_pkg::spo_code_e disp_code,
    input wire logic               disp_editing
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Mode seen at the press, so the step is judged from it
    logic [1:0] mode_cap;
    always_ff @(posedge clk) begin
        if ($rose(key_in[2])) begin
            mode_cap <= disp_mode;
        end
    end
    // ==========================================
    // Properties
    a_reset_status: assert property ($fell(sys_rst) |->
        disp_mode == spo_pkg::spo_mode_status && disp_code == spo_pkg::spo_code_bb)
        else $error("panel not in status display after reset");
    a_mode_step: assert property ($rose(key_in[2]) && !disp_editing |->
        ##[1:3] disp_mode == spo_pkg::spo_mode_e'(mode_cap + 2'h1))
        else $error("mode key did not select the next mode");
    a_enter_clear: assert property ($rose(key_in[3]) && alarm_active && !disp_editing
        && disp_mode == spo_pkg::spo_mode_status |-> ##[1:3] alarm_clear)
        else $error("enter in status mode did not clear alarm");
    a_pin_clear: assert property ($rose(alarm_reset_input) && alarm_active
        |-> ##[1:3] alarm_clear)
        else $error("alarm reset input did not clear alarm");
    a_clear_pulse: assert property (alarm_clear |=> !alarm_clear)
        else $error("alarm clear longer than one cycle");
    a_base_block: assert property ($stable(servo_on)[*3] |->
        disp_flags[1] == !servo_on)
        else $error("base block flag wrong");
    a_ctrl_power: assert property ($stable(ctrl_pwr_on)[*3] |->
        disp_flags[2] == ctrl_pwr_on)
        else $error("control power flag wrong");
    a_power_ready: assert property ($stable(main_pwr_ok)[*3] |->
        disp_flags[5] == main_pwr_ok)
        else $error("power ready flag wrong");
    a_alarm_code: assert property (alarm_active[*3] |->
        disp_code == spo_pkg::spo_code_alarm)
        else $error("alarm code not shown");
    a_fwd_stop: assert property ((!alarm_active && !forward_overtravel_input)[*3]
        |-> disp_code == spo_pkg::spo_code_fwd_stop)
        else $error("forward prohibited code not shown");
endmodule

bind spo_panel spo_panel_properties chk_inst (
    .clk(clk), .sys_rst(sys_rst), .key_in(key_in),
    .alarm_reset_input(alarm_reset_input),
    .forward_overtravel_input(forward_overtravel_input),
    .servo_on(servo_on), .ctrl_pwr_on(ctrl_pwr_on), .main_pwr_ok(main_pwr_ok),
    .alarm_active(alarm_active), .alarm_clear(alarm_clear), .disp_mode(disp_mode),
    .disp_flags(disp_flags), .disp_code(disp_code), .disp_editing(disp_editing)
);

//--- testbench/spo_operator.sv
/*
 Operator at the front keys.
 Assumes the bench calls press; keys are level, high while pressed.
*/
`timescale 1ns/1ns
module spo_operator (
    input  wire logic       clk,
    output logic      [3:0] key_in
);
    initial key_in = 4'h0;
    // Key let go and left alone after each press; the edge detect needs it
    task automatic press(input int k, input int hold);
        @(posedge clk);
        key_in[k] <= 1'b1;
        repeat (hold) @(posedge clk);
        key_in[k] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule

//--- testbench/spo_panel_tb.sv
/*
 Self-checking bench for the panel core.
 Assumes the operator model and the bound checker; short repeat counts.
*/
`timescale 1ns/1ns
module spo_panel_tb;
    logic               clk, sys_rst, alarm_reset_input, forward_overtravel_input;
    logic               reverse_overtravel_input, servo_on, ctrl_pwr_on, main_pwr_ok;
    logic               err_clr_input, ref_pulse_in, alarm_active, alarm_clear;
    logic               reg_wr, reg_rd, disp_editing;
    logic [3:0]         key_in;
    logic [15:0]        motor_speed, speed_ref, torque_ref, position_err;
    logic [7:0]         reg_addr, alarm_num, disp_alarm, disp_param_num;
    logic [31:0]        reg_wdata, reg_rdata, q;
    logic [6:0]         disp_flags;
    spo_pkg::spo_mode_e disp_mode;
    spo_pkg::spo_code_e disp_code;
    spo_pkg::spo_val_t  disp_param_val, v;
    int                 error_cnt = 0, compares = 0, clr_cnt = 0, n;
    logic [7:0]         ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h30};
    logic [31:0]        rv [7] = '{0, 32'h0a, 32'h0a, 32'h14, 0, 32'hffff, 0};

    spo_operator op_inst (.clk(clk), .key_in(key_in));
    spo_panel #(.HOLD_CYC(20), .RPT_CYC(5), .PULSE_WIN(8)) spo_panel_inst (
        .clk, .sys_rst, .key_in, .alarm_reset_input, .forward_overtravel_input,
        .reverse_overtravel_input, .servo_on, .ctrl_pwr_on, .main_pwr_ok, .err_clr_input,
        .ref_pulse_in, .motor_speed, .speed_ref, .torque_ref, .position_err, .alarm_active,
        .alarm_num, .alarm_clear, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .disp_mode, .disp_flags, .disp_code, .disp_alarm, .disp_editing, .disp_param_num,
        .disp_param_val);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (alarm_clear === 1'b1) clr_cnt++;
    // ==========================================
    // Tasks and expectations
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    function automatic int mag(input logic [15:0] x);
        return ($signed(x) < 0) ? -int'($signed(x)) : int'($signed(x));
    endfunction
    function automatic logic [6:0] exp_flags(input logic pos, input logic trq);
        logic [6:0] f;
        f[0] = pos ? mag(position_err) < 10 : (trq || mag(motor_speed - speed_ref) <= 10);
        f[1] = !servo_on;
        f[2] = ctrl_pwr_on;
        f[3] = pos ? 1'b0 : mag(speed_ref) > 20;
        f[4] = pos ? err_clr_input : mag(torque_ref) > 10;
        f[5] = main_pwr_ok;
        f[6] = mag(motor_speed) > 20;
        return f;
    endfunction
    // Values kept near the thresholds so both sides of each compare occur
    task automatic rnd(input logic pos, input logic trq);
        @(posedge clk);
        motor_speed <= 16'($urandom_range(80) - 40);
        speed_ref <= 16'($urandom_range(80) - 40);
        torque_ref <= 16'($urandom_range(30) - 15);
        position_err <= 16'($urandom_range(30) - 15);
        servo_on <= 1'($urandom);
        ctrl_pwr_on <= 1'($urandom);
        main_pwr_ok <= 1'($urandom);
        err_clr_input <= 1'($urandom);
        repeat (4) @(posedge clk);
        #1 chk(32'(exp_flags(pos, trq)), 32'(disp_flags));
    endtask
    // ==========================================
    // Main sequence
    initial begin
        #(50 * 20000);
        error_cnt++;
        close_out();
    end
    initial begin
        {sys_rst, ctrl_pwr_on, main_pwr_ok} = 3'h7;
        {forward_overtravel_input, reverse_overtravel_input} = 2'h3;
        {alarm_reset_input, servo_on, err_clr_input, ref_pulse_in, alarm_active} = 5'h0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, alarm_num} = '0;
        {motor_speed, speed_ref, torque_ref, position_err} = '0;
        void'($urandom(98363));
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1 chk(32'(disp_mode), 32'(spo_pkg::spo_mode_status));
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk(q, rv[i]);
        end
        for (int i = 1; i <= 4; i++) begin
            op_inst.press(2, 2);
            chk(32'(disp_mode), 32'(i % 4));
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            servo_on <= (i > 0);
            forward_overtravel_input <= (i != 2);
            reverse_overtravel_input <= (i != 3);
            repeat (4) @(posedge clk);
            #1 chk(32'(disp_code), 32'(i));
        end
        @(posedge clk);
        alarm_active <= 1'b1;
        alarm_num <= 8'($urandom);
        repeat (4) @(posedge clk);
        #1 chk(32'(disp_code), 32'(spo_pkg::spo_code_alarm));
        chk(32'(disp_alarm), 32'(alarm_num));
        n = clr_cnt;
        op_inst.press(3, 2);
        chk(32'(clr_cnt), 32'(n + 1));
        @(posedge clk);
        alarm_reset_input <= 1'b1;
        repeat (4) @(posedge clk);
        alarm_reset_input <= 1'b0;
        alarm_active <= 1'b0;
        chk(32'(clr_cnt), 32'(n + 2));
        repeat (40) rnd(1'b0, 1'b0);
        wr(8'h00, 32'h2);
        repeat (10) rnd(1'b0, 1'b1);
        wr(8'h00, 32'h1);
        repeat (12) @(posedge clk);
        repeat (40) rnd(1'b1, 1'b0);
        @(posedge clk);
        ref_pulse_in <= 1'b1;
        @(posedge clk);
        ref_pulse_in <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(32'(disp_flags[3]), 32'h1);
        repeat (14) @(posedge clk);
        #1 chk(32'(disp_flags[3]), 32'h0);
        op_inst.press(2, 2);
        op_inst.press(0, 2);
        chk(32'(disp_param_num), 32'h1);
        wr(8'h1c, 32'h1);
        wr(8'h20, 32'h0fff);
        wr(8'h14, 32'h1000);
        op_inst.press(3, 2);
        chk(32'(disp_editing), 32'h1);
        chk(32'(disp_param_val), 32'h0fff);
        repeat (2) op_inst.press(0, 2);
        chk(32'(disp_param_val), 32'h1000);
        wr(8'h10, 32'h0fe8);
        op_inst.press(1, 34);
        chk(32'(disp_param_val), 32'h0fe8);
        v = disp_param_val;
        op_inst.press(2, 2);
        chk(32'(disp_editing), 32'h0);
        chk(32'(disp_param_num), 32'h1);
        chk(32'(disp_mode), 32'h1);
        rd(8'h20);
        chk(q, 32'(v));
        close_out();
    end
endmodule
